// ===== design/timer_flag_bank.sv
// Timer event flag bank with Avalon-MM slave and interrupt status.
// Assumes event pulses come from timer logic on sys_clk_i and the
// break input arrives straight from a pin.
// How it works
// - Flag register lives at offset 0x10 and resets to all zeros
// - Channel 0 overrun sets on input capture while capture flag set
// - Channel 0 overrun holds until software clears it
// - Channels 1 to 3 overrun flags at bits 10 to 12, same behaviour
// - Break flag at bit 7 sets while break level is active
// - Software clears break flag only while break input is inactive
// - Trigger flag at bit 6 sets on trigger event, software clears
// - Pause mode counts both trigger edges, else only active edge
// - Commutation flag sits at bit 5
// - Commutation flag sets on commutation event, software clears
// - Channel 0 capture/compare flag at bit 1 sets on event
// - Channels 1 to 3 capture/compare flags at bits 2 to 4
// - Update flag sits at bit 0
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module timer_flag_bank
	import timer_flag_pkg::*;
(
	input  wire logic              sys_clk_i,         // System clock
	input  wire logic              reset_i,           // Sync reset, high
	input  wire logic [4:0]        avs_address_i,     // Byte address
	input  wire logic              avs_read_i,        // Read request
	input  wire logic              avs_write_i,       // Write request
	input  wire logic [DATA_W-1:0] avs_writedata_i,   // Write data
	input  wire logic [3:0]        avs_byteenable_i,  // Byte lanes
	output logic [DATA_W-1:0]      avs_readdata_o,    // Read data
	output logic                   avs_waitrequest_o, // Stall
	input  wire logic              update_event_i,    // Update pulse
	input  wire logic [CHAN_N-1:0] chan_event_i,      // Capture/compare
	input  wire logic              commut_event_i,    // Commutation
	input  wire logic              trigger_i,         // Selected trigger
	input  wire logic              break_pin_i,       // Break, async
	output logic [FLAG_W-1:0]      flags_o,           // Event flags
	output logic                   irq_o              // Interrupt level
);

	typedef enum logic [0:0] {BUS_IDLE, BUS_DONE} bus_state_t;

	bus_state_t        bus_state_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] be_bits;
	logic [FLAG_W-1:0] flags_r;
	logic [FLAG_W-1:0] flags_nxt;
	logic [FLAG_W-1:0] irq_stat_r;
	logic [FLAG_W-1:0] irq_stat_nxt;
	logic [FLAG_W-1:0] irq_mask_r;
	logic [FLAG_W-1:0] ctrl_r;
	logic [FLAG_W-1:0] set_vec;
	logic [FLAG_W-1:0] clr_vec;
	logic [FLAG_W-1:0] w1c_vec;
	logic [FLAG_W-1:0] wmask;
	logic [FLAG_W-1:0] wdata16;
	logic [CHAN_N-1:0] ovr_set;
	logic [CHAN_N-1:0] in_mode;
	logic [2:0]        slave_mode;
	logic              req;
	logic              wr_go;
	logic              brk_level;
	logic              trig_evt;
	logic              pause_mode;

	// Control fields
	assign slave_mode = ctrl_r[CTRL_MODE_LSB +: 3];
	assign in_mode    = ctrl_r[CTRL_INMODE_LSB +: CHAN_N];
	assign pause_mode = (slave_mode == MODE_PAUSE);

	// Break pin crosses into the clock domain first
	pin_sync_3ff u_break_sync (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.pin_i     (break_pin_i),
		.level_o   (brk_level)
	);

	// Trigger edges; pause mode takes both
	trig_edge_det u_trig_edge (
		.sys_clk_i    (sys_clk_i),
		.reset_i      (reset_i),
		.trig_i       (trigger_i),
		.both_edges_i (pause_mode),
		.falling_i    (ctrl_r[CTRL_TRIG_FALL]),
		.event_o      (trig_evt)
	);

	// Bus handshake: one wait cycle on every access
	assign req               = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req && (bus_state_r == BUS_IDLE);
	assign wr_go             = avs_write_i && (bus_state_r == BUS_DONE);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			bus_state_r <= BUS_IDLE;
		end else begin
			unique case (bus_state_r)
				BUS_IDLE: begin
					if (req) begin
						bus_state_r <= BUS_DONE;
					end
				end
				BUS_DONE: begin
					bus_state_r <= BUS_IDLE;
				end
			endcase
		end
	end

	// Read data captured in the wait cycle; unmapped reads zero
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rdata_r <= '0;
		end else if (avs_read_i && bus_state_r == BUS_IDLE) begin
			unique case (avs_address_i)
				OFS_CTRL:     rdata_r <= {16'h0000, ctrl_r};
				OFS_FLAGS:    rdata_r <= {16'h0000, flags_r};
				OFS_IRQ_STAT: rdata_r <= {16'h0000, irq_stat_r};
				OFS_IRQ_MASK: rdata_r <= {16'h0000, irq_mask_r};
				default:      rdata_r <= '0;
			endcase
		end
	end

	assign avs_readdata_o = rdata_r;

	// Low half of write data and lane mask
	assign be_bits = be_mask(avs_byteenable_i);
	assign wmask   = be_bits[FLAG_W-1:0];
	assign wdata16 = avs_writedata_i[FLAG_W-1:0];

	// Overrun: new capture in input mode while capture flag still up
	always_comb begin
		for (int i = 0; i < CHAN_N; i++) begin
			ovr_set[i] = chan_event_i[i] & in_mode[i]
				& flags_r[BIT_CAP0+i];
		end
	end

	// Hardware set vector, one term per flag
	always_comb begin
		set_vec = '0;
		set_vec[BIT_UPDATE] = update_event_i;
		set_vec[BIT_CAP0 +: CHAN_N] = chan_event_i;
		set_vec[BIT_COMMUT] = commut_event_i;
		set_vec[BIT_TRIG] = trig_evt;
		set_vec[BIT_BREAK] = brk_level;
		set_vec[BIT_OVR0 +: CHAN_N] = ovr_set;
	end

	// Zero written on an enabled lane clears; reserved bits never store
	assign clr_vec = (wr_go && avs_address_i == OFS_FLAGS)
		? (~wdata16 & wmask & FLAGS_IMPL) : '0;

	// Set beats clear so no event is lost; break stays while active
	assign flags_nxt = ((flags_r & ~clr_vec) | set_vec)
		& FLAGS_IMPL;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			flags_r <= FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign flags_o = flags_r;

	// Interrupt status mirrors events, cleared by writing one
	assign w1c_vec = (wr_go && avs_address_i == OFS_IRQ_STAT)
		? (wdata16 & wmask) : '0;
	assign irq_stat_nxt = ((irq_stat_r & ~w1c_vec) | set_vec) & FLAGS_IMPL;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			irq_stat_r <= IRQ_STAT_RST;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// Mask register, same layout as status
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			irq_mask_r <= IRQ_MASK_RST;
		end else if (wr_go && avs_address_i == OFS_IRQ_MASK) begin
			irq_mask_r <= ((irq_mask_r & ~wmask) | (wdata16 & wmask))
				& FLAGS_IMPL;
		end
	end

	// Control register: slave mode, trigger edge, channel input modes
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_go && avs_address_i == OFS_CTRL) begin
			ctrl_r <= ((ctrl_r & ~wmask) | (wdata16 & wmask)) & CTRL_IMPL;
		end
	end

	// Level interrupt, registered so it has no glitches
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	// Checks on the flag behaviour
	AST_RESET_ZERO: assert property (
		@(posedge sys_clk_i) reset_i |=> (flags_r == FLAGS_RST))
		else $error("flags not zero after reset");

	AST_OVR0_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(chan_event_i[0] && in_mode[0] && flags_r[BIT_CAP0])
		|=> flags_r[BIT_OVR0])
		else $error("channel 0 overrun not set");

	AST_OVR0_STICKY: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		$fell(flags_r[BIT_OVR0]) |-> $past(clr_vec[BIT_OVR0]))
		else $error("channel 0 overrun dropped without clear");

	AST_OVR3_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(chan_event_i[3] && in_mode[3] && flags_r[BIT_CAP0+3])
		##1 !$past(clr_vec[BIT_OVR0+3]) [*1] |-> flags_r[BIT_OVR0+3])
		else $error("channel 3 overrun not set");

	AST_BREAK_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		brk_level |=> flags_r[BIT_BREAK])
		else $error("break flag not set on active level");

	AST_BREAK_HOLD: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		$fell(flags_r[BIT_BREAK]) |-> !$past(brk_level))
		else $error("break flag cleared while break active");

	AST_TRIG_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		trig_evt |=> flags_r[BIT_TRIG])
		else $error("trigger flag not set");

	AST_PAUSE_EDGES: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(pause_mode && !$past(reset_i) && $changed(trigger_i))
		|-> trig_evt)
		else $error("pause mode edge missed");

	AST_COMMUT_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		commut_event_i |=> flags_r[BIT_COMMUT])
		else $error("commutation flag not set");

	AST_CAP0_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		chan_event_i[0] |=> flags_r[BIT_CAP0])
		else $error("channel 0 capture flag not set");

	AST_CAP1_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		chan_event_i[1] |=> flags_r[BIT_CAP0+1])
		else $error("channel 1 capture flag not set");

	AST_UPDATE_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		update_event_i |=> flags_r[BIT_UPDATE])
		else $error("update flag not set");

	AST_SET_WINS: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(chan_event_i[2] && clr_vec[BIT_CAP0+2]) |=> flags_r[BIT_CAP0+2])
		else $error("clear beat a hardware set");

	AST_CLEAR_WORKS: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(clr_vec[BIT_UPDATE] && !update_event_i) |=> !flags_r[BIT_UPDATE])
		else $error("write of zero did not clear");

	AST_OVR1_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(chan_event_i[1] && in_mode[1] && flags_r[BIT_CAP0+1])
		|=> flags_r[BIT_OVR0+1])
		else $error("channel 1 overrun not set");

	AST_OVR2_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(chan_event_i[2] && in_mode[2] && flags_r[BIT_CAP0+2])
		|=> flags_r[BIT_OVR0+2])
		else $error("channel 2 overrun not set");

	AST_CAP3_SET: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		chan_event_i[3] |=> flags_r[BIT_CAP0+3])
		else $error("channel 3 capture flag not set");

	AST_TRIG_STICKY: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		$fell(flags_r[BIT_TRIG]) |-> $past(clr_vec[BIT_TRIG]))
		else $error("trigger flag dropped without clear");

	AST_COMMUT_STICKY: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		$fell(flags_r[BIT_COMMUT]) |-> $past(clr_vec[BIT_COMMUT]))
		else $error("commutation flag dropped without clear");

	// Outside pause mode the inactive edge must stay silent
	AST_ACTIVE_EDGE_ONLY: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(!pause_mode && !$past(reset_i) && $changed(trigger_i)
			&& (trigger_i == ctrl_r[CTRL_TRIG_FALL])) |-> !trig_evt)
		else $error("inactive trigger edge gave an event");

endmodule

// ===== design/timer_flag_pkg.sv
// Constants, register map and helpers for the timer event flag bank.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package timer_flag_pkg;

	localparam int DATA_W = 32;
	localparam int FLAG_W = 16;
	localparam int CHAN_N = 4;

	// Register byte offsets
	localparam logic [4:0] OFS_CTRL     = 5'h00;
	localparam logic [4:0] OFS_FLAGS    = 5'h10;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

	// Flag register bit positions
	localparam int BIT_UPDATE = 0;
	localparam int BIT_CAP0   = 1;
	localparam int BIT_COMMUT = 5;
	localparam int BIT_TRIG   = 6;
	localparam int BIT_BREAK  = 7;
	localparam int BIT_OVR0   = 9;

	// Reset values and implemented-bit masks
	localparam logic [15:0] FLAGS_RST    = 16'h0000;
	localparam logic [15:0] FLAGS_IMPL   = 16'h1EFF;
	localparam logic [15:0] IRQ_STAT_RST = 16'h0000;
	localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST     = 16'h0000;
	localparam logic [15:0] CTRL_IMPL    = 16'h00FF;

	// Control register fields
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_TRIG_FALL  = 3;
	localparam int CTRL_INMODE_LSB = 4;

	// Slave mode code for pause mode
	localparam logic [2:0] MODE_PAUSE = 3'h5;

	// Expand byte enables into a bit mask
	function automatic logic [DATA_W-1:0] be_mask(input logic [3:0] be);
		logic [DATA_W-1:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return m;
	endfunction

endpackage

// ===== design/pin_sync_3ff.sv
// Three-stage synchroniser for an asynchronous level input.
// Assumes the input may change at any time relative to sys_clk_i.
`timescale 1ns/1ns
module pin_sync_3ff (
	input  wire logic sys_clk_i, // System clock
	input  wire logic reset_i,   // Synchronous reset, active high
	input  wire logic pin_i,     // Asynchronous level in
	output logic      level_o    // Filtered synchronous level
);

	logic meta_r;
	logic sync2_r;
	logic sync3_r;
	logic level_r;

	// Shift chain; first stage feeds only the second
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			meta_r  <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			meta_r  <= pin_i;
			sync2_r <= meta_r;
			sync3_r <= sync2_r;
		end
	end

	// Accept a change only once stages two and three agree
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			level_r <= 1'b0;
		end else if (sync2_r == sync3_r) begin
			level_r <= sync3_r;
		end
	end

	assign level_o = level_r;

endmodule

// ===== design/trig_edge_det.sv
// Edge detector for the selected trigger input.
// Assumes the trigger is already synchronous to sys_clk_i.
`timescale 1ns/1ns
module trig_edge_det (
	input  wire logic sys_clk_i,    // System clock
	input  wire logic reset_i,      // Synchronous reset, active high
	input  wire logic trig_i,       // Trigger level
	input  wire logic both_edges_i, // Count both edges
	input  wire logic falling_i,    // Active edge is falling
	output logic      event_o       // One-cycle trigger event
);

	logic prev_r;
	logic rise;
	logic fall;

	// Previous level for edge compare
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= trig_i;
		end
	end

	// Combinational so the flag sets on the edge's next clock
	assign rise    = trig_i & ~prev_r;
	assign fall    = ~trig_i & prev_r;
	assign event_o = both_edges_i ? (rise | fall)
		: (falling_i ? fall : rise);

endmodule

// ===== testbench/tb.sv
// Self-checking bench for the timer event flag bank.
// Assumes the design files are compiled first; drives all ports itself.
`timescale 1ns/1ns
module tb;
	import timer_flag_pkg::*;
	typedef struct {logic [5:0] ev; logic [15:0] fl;} row_t;
	logic              sys_clk_i = 1'b0;
	logic              reset_i = 1'b1;
	logic [4:0]        avs_address_i = 5'h00;
	logic              avs_read_i = 1'b0;
	logic              avs_write_i = 1'b0;
	logic [DATA_W-1:0] avs_writedata_i = 32'h00000000;
	logic [3:0]        avs_byteenable_i = 4'h0;
	logic [DATA_W-1:0] avs_readdata_o;
	logic              avs_waitrequest_o;
	logic              update_event_i = 1'b0;
	logic [CHAN_N-1:0] chan_event_i = 4'h0;
	logic              commut_event_i = 1'b0;
	logic              trigger_i = 1'b0;
	logic              break_pin_i = 1'b0;
	logic [FLAG_W-1:0] flags_o;
	logic              irq_o;
	int                n_fail = 0;
	int                cmp_count = 0;
	// Ordinary event rows: {commut, chan[3:0], update} and the flag expected
	row_t rows[6] = '{'{6'h01, 16'h0001}, '{6'h02, 16'h0002},
		'{6'h04, 16'h0004}, '{6'h08, 16'h0008},
		'{6'h10, 16'h0010}, '{6'h20, 16'h0020}};

	timer_flag_bank uut (
		.sys_clk_i         (sys_clk_i),
		.reset_i           (reset_i),
		.avs_address_i     (avs_address_i),
		.avs_read_i        (avs_read_i),
		.avs_write_i       (avs_write_i),
		.avs_writedata_i   (avs_writedata_i),
		.avs_byteenable_i  (avs_byteenable_i),
		.avs_readdata_o    (avs_readdata_o),
		.avs_waitrequest_o (avs_waitrequest_o),
		.update_event_i    (update_event_i),
		.chan_event_i      (chan_event_i),
		.commut_event_i    (commut_event_i),
		.trigger_i         (trigger_i),
		.break_pin_i       (break_pin_i),
		.flags_o           (flags_o),
		.irq_o             (irq_o)
	);

	// 25 MHz clock
	always #20 sys_clk_i = ~sys_clk_i;

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Avalon-MM master; entered and left just after a rising edge.
	// Waitrequest and read data are taken at the rising edge itself,
	// before the slave's registers move; only the watchdog ends a wait.
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [15:0] d, input logic [3:0] be, output logic [31:0] q);
		avs_address_i <= a;
		avs_writedata_i <= {16'h0000, d};
		avs_byteenable_i <= be;
		if (wr)
			avs_write_i <= 1'b1;
		else
			avs_read_i <= 1'b1;
		@(posedge sys_clk_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge sys_clk_i);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask

	// Reserved bits 15:13 and 8 are always written as zero
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, d & FLAGS_IMPL, 4'h3, q);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		logic [31:0] q;
		bus(1'b0, a, 16'h0000, 4'hF, q);
		chk(q, {16'h0000, e});
	endtask

	task automatic pulse(input logic [5:0] ev);
		{commut_event_i, chan_event_i, update_event_i} <= ev;
		@(posedge sys_clk_i);
		{commut_event_i, chan_event_i, update_event_i} <= 6'h00;
		@(posedge sys_clk_i);
	endtask

	task automatic chkf(input logic [15:0] e);
		@(negedge sys_clk_i);
		chk(flags_o, e);
		@(posedge sys_clk_i);
	endtask

	// Set the trigger level under a given control word, check, then clear
	task automatic trg(input logic [15:0] c, input logic v,
		input logic [15:0] e);
		wr(OFS_CTRL, c);
		trigger_i <= v;
		repeat (4) @(posedge sys_clk_i);
		chkf(e);
		wr(OFS_FLAGS, 16'h0000);
	endtask

	// Watchdog well beyond the few hundred cycles the tests take
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		end_of_test();
	end

	initial begin
		logic [31:0] q;
		repeat (4) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(posedge sys_clk_i);
		chkf(16'h0000);
		rdc(OFS_FLAGS, FLAGS_RST);
		rdc(OFS_IRQ_STAT, IRQ_STAT_RST);
		rdc(OFS_IRQ_MASK, IRQ_MASK_RST);
		rdc(OFS_CTRL, CTRL_RST);
		$display("reset values done");
		// One row per ordinary event source (update, captures, commutation): set, read back, clear by writing zero
		foreach (rows[i]) begin
			pulse(rows[i].ev);
			chkf(rows[i].fl);
			rdc(OFS_FLAGS, rows[i].fl);
			rdc(OFS_IRQ_STAT, rows[i].fl);
			wr(OFS_FLAGS, ~rows[i].fl);
			chkf(16'h0000);
			wr(OFS_IRQ_STAT, rows[i].fl);
		end
		$display("event rows done");
		// Writing ones, or writing with lanes off, keeps the flag
		pulse(6'h01);
		wr(OFS_FLAGS, 16'hFFFF);
		bus(1'b1, OFS_FLAGS, 16'h0000, 4'h0, q);
		chkf(16'h0001);
		// Capture held during the clearing write wins; update bit clears
		chan_event_i <= 4'h4;
		wr(OFS_FLAGS, 16'h0000);
		chan_event_i <= 4'h0;
		@(posedge sys_clk_i);
		chkf(16'h0008);
		wr(OFS_FLAGS, 16'h0000);
		$display("write semantics done");
		// Overrun in input mode on every channel; sticky for many cycles
		wr(OFS_CTRL, 16'h00F0);
		for (int c = 0; c < CHAN_N; c++) begin
			pulse(6'(2 << c));
			chkf(16'(2 << c));
			pulse(6'(2 << c));
			repeat (30) @(posedge sys_clk_i);
			chkf(16'(2 << c) | 16'(16'h0200 << c));
			wr(OFS_FLAGS, 16'h0000);
			chkf(16'h0000);
		end
		// Output mode: repeated compare gives no overrun
		wr(OFS_CTRL, 16'h0000);
		pulse(6'h02);
		pulse(6'h02);
		chkf(16'h0002);
		wr(OFS_FLAGS, 16'h0000);
		$display("overrun done");
		// Trigger edges: rising mode, pause mode, falling mode
		trg(16'h0000, 1'b1, 16'h0040);
		trg(16'h0000, 1'b0, 16'h0000);
		trg({13'h0000, MODE_PAUSE}, 1'b1, 16'h0040);
		trg({13'h0000, MODE_PAUSE}, 1'b0, 16'h0040);
		trg(16'h0008, 1'b1, 16'h0000);
		trg(16'h0008, 1'b0, 16'h0040);
		$display("trigger done");
		// Break flag cannot be cleared while the break level stands
		break_pin_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		chkf(16'h0080);
		wr(OFS_FLAGS, 16'h0000);
		chkf(16'h0080);
		break_pin_i <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		chkf(16'h0080);
		wr(OFS_FLAGS, 16'h0000);
		chkf(16'h0000);
		$display("break done");
		// Interrupt: status write-one-clear, mask gating
		wr(OFS_IRQ_STAT, 16'hFFFF);
		wr(OFS_IRQ_MASK, 16'h0001);
		rdc(OFS_IRQ_MASK, 16'h0001);
		pulse(6'h01);
		chk(irq_o, 32'h1);
		wr(OFS_FLAGS, 16'h0000);
		chk(irq_o, 32'h1);
		wr(OFS_IRQ_STAT, 16'h0001);
		chk(irq_o, 32'h0);
		pulse(6'h02);
		chk(irq_o, 32'h0);
		rdc(OFS_IRQ_STAT, 16'h0002);
		wr(OFS_IRQ_MASK, 16'h0002);
		@(posedge sys_clk_i);
		chk(irq_o, 32'h1);
		wr(OFS_IRQ_STAT, 16'h0002);
		chk(irq_o, 32'h0);
		$display("interrupt done");
		// Unmapped address reads zero and ignores writes
		wr(5'h04, 16'h00FF);
		rdc(5'h04, 16'h0000);
		rdc(OFS_CTRL, 16'h0008);
		// Reset in mid-run clears set flags
		pulse(6'h21);
		reset_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(posedge sys_clk_i);
		chkf(16'h0000);
		rdc(OFS_FLAGS, 16'h0000);
		$display("mid-run reset done");
		end_of_test();
	end
endmodule
